// ### shared/dbcdp_pkg.sv
// Constants, register map and state type of the byte counter data port
package dbcdp_pkg;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CNT_B3  = 8'h88;
  localparam logic [7:0] IDX_CNT_B2  = 8'h89;
  localparam logic [7:0] IDX_CNT_B1  = 8'h8A;
  localparam logic [7:0] IDX_CNT_B0  = 8'h8B;
  localparam logic [7:0] IDX_RD_LO   = 8'h8C;
  localparam logic [7:0] IDX_RD_HI   = 8'h8D;
  localparam logic [7:0] IDX_WR_LO   = 8'h8E;
  localparam logic [7:0] IDX_WR_HI   = 8'h8F;
  localparam logic [7:0] IDX_CTRL    = 8'hA0;
  localparam logic [7:0] IDX_CFG     = 8'hA1;
  localparam logic [7:0] IDX_STAT    = 8'hA2;
  localparam logic [7:0] IDX_MASK    = 8'hA3;
  localparam logic [7:0] IDX_JOIN    = 8'hA4;

  // ==========================================================
  // Field positions
  localparam int CTRL_GO_BIT     = 0;   // Transfer go
  localparam int CTRL_DIR_BIT    = 1;   // 1: write into FIFO
  localparam int CFG_REGACC_BIT  = 0;   // Register access mode
  localparam int CFG_FREERUN_BIT = 1;   // 1: free-running, 0: count
  localparam int CFG_WIDE_BIT    = 2;   // 1: 16-bit CPU bus
  localparam int STAT_OVF_BIT    = 0;   // Counter overflow flag
  localparam int STAT_DONE_BIT   = 1;   // Count mode transfer done
  localparam int STAT_W          = 2;

  // ==========================================================
  // Reset values
  localparam logic [31:0]       CNT_RST  = 32'h0000_0000;
  localparam logic [1:0]        CTRL_RST = 2'h0;
  localparam logic [2:0]        CFG_RST  = 3'h0;
  localparam logic [STAT_W-1:0] STAT_RST = 2'h0;
  localparam logic [STAT_W-1:0] MASK_RST = 2'h0;

  // ==========================================================
  // Bus handshake states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_DECODE = 2'b01,
    ST_ACK    = 2'b11
  } dbcdp_bus_state_type;

endpackage

// ### verilog/dbcdp_counter.sv
// Loadable 32-bit up/down transfer byte counter
`timescale 1ns/10ps
`default_nettype none
module dbcdp_counter (
  input  wire logic        i_clk,       // System clock
  input  wire logic        i_rst,       // Synchronous reset
  input  wire logic [3:0]  i_load_en,   // Per byte lane load
  input  wire logic [7:0]  i_load_data, // Byte to load
  input  wire logic        i_step,      // Bytes moved this cycle
  input  wire logic        i_step_two,  // Two bytes instead of one
  input  wire logic        i_up,        // 1: count up, 0: count down
  output logic      [31:0] o_count,     // Current count
  output logic             o_end,       // Down count reaches zero
  output logic             o_wrap       // Up count wraps past max
);

  logic [32:0] step_amt;
  logic [32:0] up_sum;
  logic [32:0] dn_diff;
  logic [31:0] stepped;
  logic [31:0] next_count;

  // ==========================================================
  // Step arithmetic
  assign step_amt = i_step_two ? 33'h0_0000_0002 : 33'h0_0000_0001;
  assign up_sum   = {1'b0, o_count} + step_amt;
  assign dn_diff  = {1'b0, o_count} - step_amt;
  // Down count saturates at zero on a one-byte or a two-byte step
  assign stepped  = !i_step ? o_count :
                    i_up ? up_sum[31:0] :
                    dn_diff[32] ? 32'h0000_0000 : dn_diff[31:0];
  assign o_wrap   = i_step && i_up && up_sum[32];
  assign o_end    = i_step && !i_up && (dn_diff[32] || dn_diff[31:0] == 32'h0000_0000);

  // ==========================================================
  // Byte lane load overrides the step
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign next_count[8*g +: 8] = i_load_en[g] ? i_load_data : stepped[8*g +: 8];
    end
  endgenerate

  // Count register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_count <= dbcdp_pkg::CNT_RST;
    end else begin
      o_count <= next_count;
    end
  end

endmodule
`default_nettype wire

// ### verilog/dbcdp_top.sv
// Byte counter and register data port of a DMA channel
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module dbcdp_top #(
  parameter int NUM_FIFO = 4,                // FIFOs that can be joined
  parameter int SEL_W    = 2                 // Width of the join select
) (
  input  wire logic             i_clk,             // 40 MHz system clock
  input  wire logic             i_rst,             // Synchronous reset
  input  wire logic [9:0]       i_avs_address,     // Byte address
  input  wire logic             i_avs_read,        // Read request
  input  wire logic             i_avs_write,       // Write request
  input  wire logic [3:0]       i_avs_byteenable,  // Byte lanes
  input  wire logic [31:0]      i_avs_writedata,   // Write data
  output logic      [31:0]      o_avs_readdata,    // Read data
  output logic                  o_avs_waitrequest, // Stall
  output logic                  o_irq,             // Level interrupt
  input  wire logic [15:0]      i_fifo_rdata,      // Joined FIFO head
  input  wire logic             i_fifo_empty,      // Too few bytes
  input  wire logic             i_fifo_full,       // Too little room
  output logic                  o_fifo_pop,        // Take bytes
  output logic                  o_fifo_push,       // Put bytes
  output logic      [15:0]      o_fifo_wdata,      // Bytes to put
  output logic                  o_fifo_wide,       // Two bytes a move
  output logic      [SEL_W-1:0] o_fifo_sel,        // Joined FIFO
  input  wire logic             i_chan_byte,       // Engine moved a byte
  output logic                  o_chan_active,     // Transfer running
  output logic                  o_chan_dir         // 1: into FIFO
);

  // ==========================================================
  // Parameter check
  generate
    if (NUM_FIFO < 1 || NUM_FIFO > (1 << SEL_W) || SEL_W > 8) begin : g_bad
      $error("dbcdp_top: NUM_FIFO does not fit SEL_W");
    end
  endgenerate

  dbcdp_pkg::dbcdp_bus_state_type state;
  logic                    cfg_regacc;
  logic                    cfg_freerun;
  logic [dbcdp_pkg::STAT_W-1:0] stat;
  logic [dbcdp_pkg::STAT_W-1:0] mask;
  logic [dbcdp_pkg::STAT_W-1:0] next_stat;
  logic [31:0]             snap;
  logic [31:0]             count;
  logic                    cnt_end;
  logic                    cnt_wrap;
  logic [7:0]              idx;
  logic                    is_rd_port;
  logic                    is_wr_port;
  logic                    fifo_rd;
  logic                    fifo_wr;
  logic                    stall;
  logic                    fire;
  logic                    reg_wr;
  logic                    step_en;
  logic                    step_two;
  logic [3:0]              load_en;
  logic [31:0]             next_rdata;

  // ==========================================================
  // Access decode
  assign idx        = i_avs_address[9:2];
  assign is_rd_port = (idx == dbcdp_pkg::IDX_RD_LO) || (idx == dbcdp_pkg::IDX_RD_HI);
  assign is_wr_port = (idx == dbcdp_pkg::IDX_WR_LO) || (idx == dbcdp_pkg::IDX_WR_HI);
  // Port moves only in register access mode and matching direction
  assign fifo_rd    = i_avs_read && is_rd_port && cfg_regacc && !o_chan_dir;
  assign fifo_wr    = i_avs_write && is_wr_port && cfg_regacc && o_chan_dir;
  assign stall      = (fifo_rd && i_fifo_empty) || (fifo_wr && i_fifo_full);
  assign fire       = (state == dbcdp_pkg::ST_DECODE) && !stall;
  assign reg_wr     = fire && i_avs_write && i_avs_byteenable[0];

  // Bytes counted while a transfer runs
  assign step_en  = o_chan_active && ((fire && (fifo_rd || fifo_wr)) ||
                    (!cfg_regacc && i_chan_byte));
  assign step_two = fire && (fifo_rd || fifo_wr) && o_fifo_wide;

  // Counter lane loads, lane 3 at the lowest index
  assign load_en[3] = reg_wr && (idx == dbcdp_pkg::IDX_CNT_B3);
  assign load_en[2] = reg_wr && (idx == dbcdp_pkg::IDX_CNT_B2);
  assign load_en[1] = reg_wr && (idx == dbcdp_pkg::IDX_CNT_B1);
  assign load_en[0] = reg_wr && (idx == dbcdp_pkg::IDX_CNT_B0);

  // ==========================================================
  // Byte counter
  dbcdp_counter u_counter (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_load_en   (load_en),
    .i_load_data (i_avs_writedata[7:0]),
    .i_step      (step_en),
    .i_step_two  (step_two),
    .i_up        (cfg_freerun),
    .o_count     (count),
    .o_end       (cnt_end),
    .o_wrap      (cnt_wrap)
  );

  // ==========================================================
  // Bus handshake
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state             <= dbcdp_pkg::ST_IDLE;
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !fire;
      case (state)
        dbcdp_pkg::ST_IDLE: begin
          if (i_avs_read || i_avs_write) begin
            state <= dbcdp_pkg::ST_DECODE;
          end
        end
        dbcdp_pkg::ST_DECODE: begin
          if (!stall) begin
            state <= dbcdp_pkg::ST_ACK;
          end
        end
        default: begin
          state <= dbcdp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Read data select; lower bytes come from the snapshot
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (idx)
      dbcdp_pkg::IDX_CNT_B3: next_rdata[7:0] = count[31:24];
      dbcdp_pkg::IDX_CNT_B2: next_rdata[7:0] = snap[23:16];
      dbcdp_pkg::IDX_CNT_B1: next_rdata[7:0] = snap[15:8];
      dbcdp_pkg::IDX_CNT_B0: next_rdata[7:0] = snap[7:0];
      dbcdp_pkg::IDX_RD_LO, dbcdp_pkg::IDX_RD_HI: begin
        if (fifo_rd) begin
          next_rdata[15:0] = o_fifo_wide ? i_fifo_rdata :
                             {8'h00, i_fifo_rdata[7:0]};
        end
      end
      dbcdp_pkg::IDX_CTRL: next_rdata[1:0] = {o_chan_dir, o_chan_active};
      dbcdp_pkg::IDX_CFG:  next_rdata[2:0] = {o_fifo_wide, cfg_freerun, cfg_regacc};
      dbcdp_pkg::IDX_STAT: next_rdata[dbcdp_pkg::STAT_W-1:0] = stat;
      dbcdp_pkg::IDX_MASK: next_rdata[dbcdp_pkg::STAT_W-1:0] = mask;
      dbcdp_pkg::IDX_JOIN: next_rdata[SEL_W-1:0] = o_fifo_sel;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data register and counter snapshot
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h0000_0000;
      snap           <= dbcdp_pkg::CNT_RST;
    end else if (fire && i_avs_read) begin
      o_avs_readdata <= next_rdata;
      if (idx == dbcdp_pkg::IDX_CNT_B3) begin
        snap <= count;
      end
    end
  end

  // ==========================================================
  // Control and configuration; count end clears go
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      {o_chan_dir, o_chan_active}            <= dbcdp_pkg::CTRL_RST;
      {o_fifo_wide, cfg_freerun, cfg_regacc} <= dbcdp_pkg::CFG_RST;
      o_fifo_sel                             <= '0;
    end else begin
      if (reg_wr && idx == dbcdp_pkg::IDX_CTRL) begin
        o_chan_active <= i_avs_writedata[dbcdp_pkg::CTRL_GO_BIT];
        o_chan_dir    <= i_avs_writedata[dbcdp_pkg::CTRL_DIR_BIT];
      end else if (cnt_end) begin
        o_chan_active <= 1'b0;
      end
      if (reg_wr && idx == dbcdp_pkg::IDX_CFG) begin
        cfg_regacc  <= i_avs_writedata[dbcdp_pkg::CFG_REGACC_BIT];
        cfg_freerun <= i_avs_writedata[dbcdp_pkg::CFG_FREERUN_BIT];
        o_fifo_wide <= i_avs_writedata[dbcdp_pkg::CFG_WIDE_BIT];
      end
      if (reg_wr && idx == dbcdp_pkg::IDX_JOIN) begin
        o_fifo_sel <= i_avs_writedata[SEL_W-1:0];
      end
    end
  end

  // ==========================================================
  // FIFO strobes and write data
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_fifo_pop   <= 1'b0;
      o_fifo_push  <= 1'b0;
      o_fifo_wdata <= 16'h0000;
    end else begin
      o_fifo_pop  <= fire && fifo_rd;
      o_fifo_push <= fire && fifo_wr;
      if (fire && fifo_wr) begin
        o_fifo_wdata <= o_fifo_wide ? i_avs_writedata[15:0] :
                        {8'h00, i_avs_writedata[7:0]};
      end
    end
  end

  // ==========================================================
  // Interrupt status, write one to clear, set wins
  always_comb begin
    next_stat = stat;
    if (reg_wr && idx == dbcdp_pkg::IDX_STAT) begin
      next_stat = stat & ~i_avs_writedata[dbcdp_pkg::STAT_W-1:0];
    end
    next_stat[dbcdp_pkg::STAT_OVF_BIT]  = next_stat[dbcdp_pkg::STAT_OVF_BIT] | cnt_wrap;
    next_stat[dbcdp_pkg::STAT_DONE_BIT] = next_stat[dbcdp_pkg::STAT_DONE_BIT] | cnt_end;
  end

  // Status, mask and interrupt line
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stat  <= dbcdp_pkg::STAT_RST;
      mask  <= dbcdp_pkg::MASK_RST;
      o_irq <= 1'b0;
    end else begin
      stat  <= next_stat;
      o_irq <= |(stat & mask);
      if (reg_wr && idx == dbcdp_pkg::IDX_MASK) begin
        mask <= i_avs_writedata[dbcdp_pkg::STAT_W-1:0];
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // One access: served in decode, one cycle of low waitrequest
  sequence s_served;
    fire ##1 !o_avs_waitrequest;
  endsequence
  sequence s_released;
    o_avs_waitrequest [*2];
  endsequence

  ack_one_cycle_a: assert property (s_served |=> s_released)
    else $error("waitrequest low for more than one cycle");
  pop_has_data_a: assert property (o_fifo_pop |-> $past(!i_fifo_empty && cfg_regacc))
    else $error("pop without data or outside register access");
  read_port_data_a: assert property (fire && fifo_rd && !o_fifo_wide |=>
      o_avs_readdata == {24'h00_0000, $past(i_fifo_rdata[7:0])})
    else $error("read port did not return FIFO byte");
  push_data_a: assert property (fire && fifo_wr && o_fifo_wide |=>
      o_fifo_push && o_fifo_wdata == $past(i_avs_writedata[15:0]))
    else $error("pushed word differs from written word");
  count_down_a: assert property (step_en && !cfg_freerun && !step_two &&
      count > 32'h0000_0000 && load_en == 4'h0 |=> count == $past(count) - 32'h0000_0001)
    else $error("count mode did not decrement by one");
  count_up_a: assert property (step_en && cfg_freerun && load_en == 4'h0 |=>
      count == $past(count) + {30'h0, $past(step_two), !$past(step_two)})
    else $error("free-running count did not increment");
  overflow_flag_a: assert property (cnt_wrap |=> stat[dbcdp_pkg::STAT_OVF_BIT]
      ##1 o_irq == mask[dbcdp_pkg::STAT_OVF_BIT] || stat[dbcdp_pkg::STAT_DONE_BIT])
    else $error("wrap did not set overflow flag");
  wrap_keeps_going_a: assert property (cnt_wrap && cfg_freerun |=> o_chan_active
      == $past(o_chan_active) || $past(reg_wr))
    else $error("transfer stopped on wrap");
  end_stops_a: assert property (cnt_end && !(reg_wr && idx == dbcdp_pkg::IDX_CTRL)
      |=> !o_chan_active && stat[dbcdp_pkg::STAT_DONE_BIT])
    else $error("count end did not stop the transfer");
  snapshot_a: assert property (fire && i_avs_read && idx == dbcdp_pkg::IDX_CNT_B3
      |=> snap == $past(count) && o_avs_readdata[7:0] == snap[31:24])
    else $error("snapshot differs from count");
  reset_zero_a: assert property ($past(i_rst) |-> count == 32'h0000_0000 && !o_chan_active)
    else $error("counter not zero after reset");

endmodule
`default_nettype wire

// ### testbench/dbcdp_fifo_model.sv
// Behavioural FIFO joined to the channel, far side of the data port
`timescale 1ns/10ps
`default_nettype none
module dbcdp_fifo_model #(
  parameter int DEPTH = 8               // Bytes of storage
) (
  input  wire logic        i_clk,       // System clock
  input  wire logic        i_rst,       // Synchronous reset
  input  wire logic        i_pop,       // Consume head bytes
  input  wire logic        i_push,      // Store bytes
  input  wire logic        i_wide,      // Two bytes a move
  input  wire logic [15:0] i_wdata,     // Bytes to store
  output logic      [15:0] o_rdata,     // Head bytes
  output logic             o_empty,     // Too few bytes
  output logic             o_full       // Too little room
);
  logic [7:0] q[$];
  int         w;

  initial begin
    o_rdata = 16'h0000;
    o_empty = 1'b1;
    o_full  = 1'b0;
  end

  // Bytes leave in arrival order; empty head shows a changing pattern
  always @(posedge i_clk) begin
    w = i_wide ? 2 : 1;
    if (i_rst) begin
      q.delete();
    end else begin
      if (i_pop) begin
        repeat (w) if (q.size() > 0) void'(q.pop_front());
      end
      if (i_push) begin
        q.push_back(i_wdata[7:0]);
        if (i_wide) q.push_back(i_wdata[15:8]);
      end
    end
    o_empty <= q.size() < w;
    o_full  <= q.size() + w > DEPTH;
    o_rdata <= {(q.size() > 1) ? q[1] : ~o_rdata[15:8], (q.size() > 0) ? q[0] : ~o_rdata[7:0]};
  end
endmodule
`default_nettype wire

// ### testbench/dbcdp_top_tb.sv
// Self-checking bench of the byte counter data port
`timescale 1ns/10ps
`default_nettype none
module dbcdp_top_tb;
  logic        clk, rst, rd, wr, chan_byte, irq, pop, push, wide, active, dir, empty, full;
  logic        wait_req;
  logic [9:0]  addr;
  logic [3:0]  be;
  logic [31:0] wdata, rdata, v, x, n;
  logic [15:0] fwdata, frdata;
  logic [1:0]  sel;
  int          mismatches, n_compared, seed, i;

  dbcdp_top dbcdp_top_inst (.i_clk(clk), .i_rst(rst), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(be), .i_avs_writedata(wdata),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .o_irq(irq),
    .i_fifo_rdata(frdata), .i_fifo_empty(empty), .i_fifo_full(full), .o_fifo_pop(pop),
    .o_fifo_push(push), .o_fifo_wdata(fwdata), .o_fifo_wide(wide), .o_fifo_sel(sel),
    .i_chan_byte(chan_byte), .o_chan_active(active), .o_chan_dir(dir));

  dbcdp_fifo_model dbcdp_fifo_model_inst (.i_clk(clk), .i_rst(rst), .i_pop(pop),
    .i_push(push), .i_wide(wide), .i_wdata(fwdata), .o_rdata(frdata), .o_empty(empty),
    .o_full(full));

  // ==========================================================
  // Clock, verdict and watchdog
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  // ==========================================================
  // Comparison and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [7:0] idx, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    addr  <= {idx, 2'h0};
    rd    <= ~w;
    wr    <= w;
    wdata <= d;
    @(posedge clk);
    while (wait_req !== 1'b0) @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] t;
    acc(1'b1, idx, d, t);
  endtask

  task automatic rreg(input logic [7:0] idx, output logic [31:0] q);
    acc(1'b0, idx, 32'h0, q);
  endtask

  // Counter load, any byte order; read top byte first
  task automatic ld(input logic [31:0] c);
    for (int b = 0; b < 4; b++) wreg(dbcdp_pkg::IDX_CNT_B3 + 8'(b), c >> (8 * (3 - b)));
  endtask

  task automatic rdcnt(output logic [31:0] c);
    logic [31:0] t;
    c = 32'h0;
    for (int b = 0; b < 4; b++) begin
      rreg(dbcdp_pkg::IDX_CNT_B3 + 8'(b), t);
      c = {c[23:0], t[7:0]};
    end
  endtask

  task automatic pulse(input logic [31:0] k);
    repeat (k) begin
      @(posedge clk);
      chan_byte <= 1'b1;
      @(posedge clk);
      chan_byte <= 1'b0;
    end
    repeat (2) @(posedge clk);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    seed = 24;
    rst = 1'b1;
    {rd, wr, chan_byte} = 3'h0;
    addr = 10'h000;
    be = 4'hF;
    wdata = 32'h0;
    mismatches = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdcnt(x); chk(x, 32'h0);
    // Counter load and readback, all-ones first
    for (i = 0; i < 4; i++) begin
      v = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
      ld(v); rdcnt(x); chk(x, v);
    end
    ld(v); rreg(dbcdp_pkg::IDX_CNT_B3, x); wreg(dbcdp_pkg::IDX_CNT_B0, ~v);
    rreg(dbcdp_pkg::IDX_CNT_B0, x); chk(x, {24'h0, v[7:0]});
    // Count mode run to the end
    n = 32'h3 + ($random(seed) & 32'h3);
    ld(n); wreg(dbcdp_pkg::IDX_CFG, 32'h0); wreg(dbcdp_pkg::IDX_CTRL, 32'h1);
    pulse(32'h1); rdcnt(x); chk(x, n - 32'h1);
    pulse(n - 32'h2); chk({31'h0, active}, 32'h1);
    pulse(32'h1); chk({31'h0, active}, 32'h0);
    rdcnt(x); chk(x, 32'h0);
    rreg(dbcdp_pkg::IDX_STAT, x); chk(x, 32'h2);
    wreg(dbcdp_pkg::IDX_STAT, 32'h3); rreg(dbcdp_pkg::IDX_STAT, x); chk(x, 32'h0);
    // Free-running wrap, interrupt mask and clear
    ld(32'hFFFF_FFFE); wreg(dbcdp_pkg::IDX_CFG, 32'h2); wreg(dbcdp_pkg::IDX_CTRL, 32'h1);
    pulse(32'h3); rdcnt(x); chk(x, 32'h1);
    chk({31'h0, active}, 32'h1);
    rreg(dbcdp_pkg::IDX_STAT, x); chk(x, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wreg(dbcdp_pkg::IDX_MASK, 32'h1); repeat (2) @(posedge clk); chk({31'h0, irq}, 32'h1);
    wreg(dbcdp_pkg::IDX_STAT, 32'h1); repeat (2) @(posedge clk); chk({31'h0, irq}, 32'h0);
    wreg(dbcdp_pkg::IDX_CTRL, 32'h0);
    // Every join select value
    for (i = 0; i < 4; i++) begin
      wreg(dbcdp_pkg::IDX_JOIN, i); chk({30'h0, sel}, i);
    end
    // Byte ports, then wrong direction, then word ports
    v = $random(seed);
    wreg(dbcdp_pkg::IDX_CFG, 32'h1); wreg(dbcdp_pkg::IDX_CTRL, 32'h2);
    chk({31'h0, dir}, 32'h1);
    wreg(dbcdp_pkg::IDX_WR_LO, v[7:0]); wreg(dbcdp_pkg::IDX_WR_HI, v[15:8]);
    wreg(dbcdp_pkg::IDX_CTRL, 32'h0);
    rreg(dbcdp_pkg::IDX_RD_HI, x); chk(x, {24'h0, v[7:0]});
    rreg(dbcdp_pkg::IDX_RD_LO, x); chk(x, {24'h0, v[15:8]});
    wreg(dbcdp_pkg::IDX_CTRL, 32'h2); rreg(dbcdp_pkg::IDX_RD_LO, x); chk(x, 32'h0);
    // Word port move while counting: one access steps the count by two
    ld(32'h10); wreg(dbcdp_pkg::IDX_CFG, 32'h5); wreg(dbcdp_pkg::IDX_CTRL, 32'h3);
    wreg(dbcdp_pkg::IDX_WR_HI, v[31:16]);
    wreg(dbcdp_pkg::IDX_CTRL, 32'h0); rdcnt(x); chk(x, 32'hE);
    rreg(dbcdp_pkg::IDX_RD_LO, x); chk(x, {16'h0, v[31:16]});
    rreg(8'h90, x); chk(x, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
